// ### ftx_pkg.sv
// Constants for the transmit and framer alarm event status block.
package ftx_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_TX_STATUS = 8'h00;
  localparam logic [7:0] OFS_ALARM_STATUS = 8'h04;
  localparam logic [7:0] OFS_TX_MASK = 8'h08;
  localparam logic [7:0] OFS_ALARM_MASK = 8'h0C;
  localparam logic [7:0] OFS_GLOBAL_CONFIG = 8'h10;
  localparam logic [7:0] OFS_GLOBAL_SUMMARY = 8'h14;
  // Transmit event status bits
  localparam int TXB_UNDERRUN = 4;
  localparam int TXB_MF_BEGIN = 3;
  localparam int TXB_SUE = 2;
  localparam int TXB_LINE_CHG = 1;
  localparam int TXB_POOL_RDY = 0;
  localparam logic [7:0] TX_IMPL_MASK = 8'h1F;
  // Framer alarm status bits
  localparam int ALB_FRAME_REGAIN = 7;
  localparam int ALB_FRAME_LOST = 6;
  localparam int ALB_MF_REGAIN = 5;
  localparam int ALB_MF_LOST = 4;
  localparam int ALB_BLUE = 3;
  localparam int ALB_RED = 2;
  localparam int ALB_YEL_CLR = 1;
  localparam int ALB_YEL = 0;
  // Global config bits
  localparam int GCB_VISIBLE = 0;
  localparam int GCB_COS = 1;
  // Global summary bits
  localparam int GSB_TX = 0;
  localparam int GSB_ALARM = 1;
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [1:0] RST_GCFG = 2'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Repeat period of the signaling unit error event while a bad frame persists
  localparam int CLK_PERIOD_NS = 10;
  localparam int SUE_REPEAT_NS = 10000;
  localparam int SUE_REPEAT_CYC = SUE_REPEAT_NS / CLK_PERIOD_NS;
  localparam int SUE_CNT_W = 10;
  localparam logic [SUE_CNT_W-1:0] SUE_REPEAT_LAST = SUE_CNT_W'(SUE_REPEAT_CYC - 1);
endpackage : ftx_pkg

// ### ftx_irq_status.sv
// Transmit/HDLC and framer alarm event status registers with AXI4-Lite access.
// Behaviour
// RL1: Underrun mid-frame without end command aborts, flags.
// RL2: Underrun disables transmitter until status read.
// RL3: Software should keep underrun interrupt unmasked.
// RL4: Flag each transmitted multiframe start.
// RL5: SS7 only: flag when error count exceeds threshold.
// RL6: Bad-frame cause repeats error event until valid.
// RL7: Flag overload rise or any short change.
// RL8: Flag when queue has room for 32 bytes.
// RL9: Reading alarm status clears all its flags.
// RL10: Visible mode records masked events, no interrupt.
// RL11: Frame regain on sync-lost fall, sim end.
// RL12: Frame lost when sync lost, or simulating.
// RL13: Multiframe regain on fall in F12/F72, sim.
// RL14: Multiframe lost on rise in F12/F72, sim.
// RL15: Blue alarm set, change-of-state option, sim.
// RL16: Red alarm set, change-of-state option, sim.
// RL17: Yellow cleared on fall, or sim end clear.
// RL18: Yellow alarm on rise, and during simulation.
// RL19: Reading transmit status clears it, re-enables transmitter.
// RL20: Interrupt while any unmasked flag is set.
module ftx_irq_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hdlc_tx_queue_empty,
  input wire logic tx_frame_active,
  input wire logic tx_message_end_cmd,
  input wire logic tx_multiframe_start,
  input wire logic ss7_mode,
  input wire logic sue_count_exceeded,
  input wire logic sue_bad_frame,
  input wire logic sue_valid_frame,
  input wire logic tx_line_overload_bit,
  input wire logic tx_line_short_bit,
  input wire logic hdlc_tx_queue_room_32,
  input wire logic frame_sync_lost,
  input wire logic multiframe_sync_lost,
  input wire logic mf_format_f12_f72,
  input wire logic blue_alarm,
  input wire logic red_alarm,
  input wire logic remote_alarm_status_bit,
  input wire logic alarm_sim_active,
  output logic tx_abort_req,
  output logic tx_disabled,
  output logic event_irq
);

  typedef struct packed {
    logic [7:0] tx_stat;
    logic [7:0] al_stat;
    logic [7:0] tx_mask;
    logic [7:0] al_mask;
    logic [1:0] gcfg;
    logic tx_off;
    logic abort;
    logic p_ovl;
    logic p_short;
    logic p_room;
    logic p_lfa;
    logic p_multiframe_sync_lost;
    logic p_blue;
    logic p_red;
    logic p_rra;
    logic p_sim;
    logic p_sue;
    logic sue_bad;
    logic [ftx_pkg::SUE_CNT_W-1:0] sue_cnt;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ftx_state_t;

  ftx_state_t q;
  ftx_state_t next_q;

  // Masked events are only kept when visible mode is on
  function automatic logic [7:0] ftx_record(input logic [7:0] ev, input logic [7:0] mask,
                                            input logic visible_masked_status_en);
    ftx_record = ev & (~mask | {8{visible_masked_status_en}});
  endfunction : ftx_record

  function automatic logic ftx_pending(input logic [7:0] stat, input logic [7:0] mask);
    ftx_pending = |(stat & ~mask);
  endfunction : ftx_pending

  logic underrun;
  logic sue_tick;
  logic sim_end;
  logic rd_take;
  logic rd_tx;
  logic rd_al;
  logic [7:0] tx_ev;
  logic [7:0] al_ev;
  logic cos;
  logic underrun_hidden;

  assign cos = q.gcfg[ftx_pkg::GCB_COS];
  // Masked underrun outside visible mode is not recorded, lockout still applies
  assign underrun_hidden = q.tx_mask[ftx_pkg::TXB_UNDERRUN] & ~q.gcfg[ftx_pkg::GCB_VISIBLE];
  assign sim_end = q.p_sim & ~alarm_sim_active;
  assign underrun = tx_frame_active & hdlc_tx_queue_empty & ~tx_message_end_cmd & ~q.tx_off; // [RL1]
  assign sue_tick = q.sue_bad && (q.sue_cnt == ftx_pkg::SUE_REPEAT_LAST);
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rd_tx = rd_take && (s_axi_araddr == ftx_pkg::OFS_TX_STATUS);
  assign rd_al = rd_take && (s_axi_araddr == ftx_pkg::OFS_ALARM_STATUS);

  always_comb begin
    tx_ev = 8'h00;
    tx_ev[ftx_pkg::TXB_UNDERRUN] = underrun; // [RL1]
    tx_ev[ftx_pkg::TXB_MF_BEGIN] = tx_multiframe_start; // [RL4]
    tx_ev[ftx_pkg::TXB_SUE] = ss7_mode & sue_count_exceeded & (~q.p_sue | sue_tick); // [RL5] [RL6]
    tx_ev[ftx_pkg::TXB_LINE_CHG] = (tx_line_overload_bit & ~q.p_ovl)
                                   | (tx_line_short_bit ^ q.p_short); // [RL7]
    tx_ev[ftx_pkg::TXB_POOL_RDY] = hdlc_tx_queue_room_32 & ~q.p_room & ~q.tx_off; // [RL8]
    al_ev = 8'h00;
    al_ev[ftx_pkg::ALB_FRAME_REGAIN] = (q.p_lfa & ~frame_sync_lost)
                                       | (sim_end & ~frame_sync_lost); // [RL11]
    al_ev[ftx_pkg::ALB_FRAME_LOST] = (frame_sync_lost & ~q.p_lfa) | alarm_sim_active; // [RL12]
    al_ev[ftx_pkg::ALB_MF_REGAIN] = (mf_format_f12_f72 & q.p_multiframe_sync_lost & ~multiframe_sync_lost)
                                    | alarm_sim_active; // [RL13]
    al_ev[ftx_pkg::ALB_MF_LOST] = (mf_format_f12_f72 & multiframe_sync_lost & ~q.p_multiframe_sync_lost)
                                  | alarm_sim_active; // [RL14]
    al_ev[ftx_pkg::ALB_BLUE] = (cos ? (blue_alarm ^ q.p_blue) : (blue_alarm & ~q.p_blue))
                               | alarm_sim_active; // [RL15]
    al_ev[ftx_pkg::ALB_RED] = (cos ? (red_alarm ^ q.p_red) : (red_alarm & ~q.p_red))
                              | alarm_sim_active; // [RL16]
    al_ev[ftx_pkg::ALB_YEL_CLR] = (q.p_rra & ~remote_alarm_status_bit)
                                  | (sim_end & ~remote_alarm_status_bit); // [RL17]
    al_ev[ftx_pkg::ALB_YEL] = (remote_alarm_status_bit & ~q.p_rra) | alarm_sim_active; // [RL18]
  end

  always_comb begin
    next_q = q;
    next_q.p_ovl = tx_line_overload_bit;
    next_q.p_short = tx_line_short_bit;
    next_q.p_room = hdlc_tx_queue_room_32;
    next_q.p_lfa = frame_sync_lost;
    next_q.p_multiframe_sync_lost = multiframe_sync_lost;
    next_q.p_blue = blue_alarm;
    next_q.p_red = red_alarm;
    next_q.p_rra = remote_alarm_status_bit;
    next_q.p_sim = alarm_sim_active;
    next_q.p_sue = ss7_mode & sue_count_exceeded;
    next_q.abort = underrun; // [RL1]

    // Bad-frame cause held until a valid frame arrives or SS7 mode is left
    if (sue_valid_frame || !ss7_mode) begin
      next_q.sue_bad = 1'b0; // [RL6]
    end else if (sue_bad_frame && sue_count_exceeded) begin
      next_q.sue_bad = 1'b1; // [RL6]
    end
    if (!q.sue_bad || sue_tick) begin
      next_q.sue_cnt = '0;
    end else begin
      next_q.sue_cnt = q.sue_cnt + 1'b1;
    end

    // Read clears, new events win over the clear
    if (rd_tx) begin
      next_q.tx_stat = ftx_pkg::RST_STATUS; // [RL19]
    end
    if (rd_al) begin
      next_q.al_stat = ftx_pkg::RST_STATUS; // [RL9]
    end
    next_q.tx_stat = next_q.tx_stat
                     | ftx_record(tx_ev, q.tx_mask, q.gcfg[ftx_pkg::GCB_VISIBLE]); // [RL10]
    next_q.al_stat = next_q.al_stat
                     | ftx_record(al_ev, q.al_mask, q.gcfg[ftx_pkg::GCB_VISIBLE]); // [RL10]

    // Transmitter stays locked out until the status register is read
    if (underrun) begin
      next_q.tx_off = 1'b1; // [RL2]
    end else if (rd_tx) begin
      next_q.tx_off = 1'b0; // [RL19]
    end

    // Write channel: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_ok = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_ok = 1'b1;
      next_q.w_data = s_axi_wdata[7:0];
      next_q.w_lane0 = s_axi_wstrb[0];
    end
    if (q.aw_ok && q.w_ok && !q.bvalid) begin
      next_q.aw_ok = 1'b0;
      next_q.w_ok = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = ftx_pkg::RESP_OKAY;
      unique case (q.aw_addr)
        ftx_pkg::OFS_TX_MASK: begin
          if (q.w_lane0) begin
            next_q.tx_mask = q.w_data & ftx_pkg::TX_IMPL_MASK;
          end
        end
        ftx_pkg::OFS_ALARM_MASK: begin
          if (q.w_lane0) begin
            next_q.al_mask = q.w_data;
          end
        end
        ftx_pkg::OFS_GLOBAL_CONFIG: begin
          if (q.w_lane0) begin
            next_q.gcfg = q.w_data[1:0];
          end
        end
        // Status and summary are read-only; writes are dropped
        ftx_pkg::OFS_TX_STATUS, ftx_pkg::OFS_ALARM_STATUS, ftx_pkg::OFS_GLOBAL_SUMMARY: begin
        end
        default: begin
          next_q.bresp = ftx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // Read channel: one-cycle answer, status snapshot before clear
    if (rd_take) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = ftx_pkg::RESP_OKAY;
      next_q.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        ftx_pkg::OFS_TX_STATUS: next_q.rdata[7:0] = q.tx_stat;
        ftx_pkg::OFS_ALARM_STATUS: next_q.rdata[7:0] = q.al_stat;
        ftx_pkg::OFS_TX_MASK: next_q.rdata[7:0] = q.tx_mask;
        ftx_pkg::OFS_ALARM_MASK: next_q.rdata[7:0] = q.al_mask;
        ftx_pkg::OFS_GLOBAL_CONFIG: next_q.rdata[1:0] = q.gcfg;
        ftx_pkg::OFS_GLOBAL_SUMMARY: begin
          next_q.rdata[ftx_pkg::GSB_TX] = ftx_pending(q.tx_stat, q.tx_mask); // [RL10]
          next_q.rdata[ftx_pkg::GSB_ALARM] = ftx_pending(q.al_stat, q.al_mask); // [RL10]
        end
        default: next_q.rresp = ftx_pkg::RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.tx_stat <= ftx_pkg::RST_STATUS;
      q.al_stat <= ftx_pkg::RST_STATUS;
      q.tx_mask <= ftx_pkg::RST_MASK;
      q.al_mask <= ftx_pkg::RST_MASK;
      q.gcfg <= ftx_pkg::RST_GCFG;
      q.bresp <= ftx_pkg::RESP_OKAY;
      q.rresp <= ftx_pkg::RESP_OKAY;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = ~q.aw_ok & ~q.bvalid;
  assign s_axi_wready = ~q.w_ok & ~q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign tx_abort_req = q.abort;
  assign tx_disabled = q.tx_off; // [RL2]
  // Masking the underrun hides a locked transmitter from software
  assign event_irq = ftx_pending(q.tx_stat, q.tx_mask)
                     | ftx_pending(q.al_stat, q.al_mask); // [RL20] [RL3]

  chk_underrun_abort: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
    underrun |=> tx_abort_req && tx_disabled
      && (q.tx_stat[ftx_pkg::TXB_UNDERRUN] || $past(underrun_hidden)))
    else $error("underrun did not abort and flag");

  chk_lockout_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RL2]
    (tx_disabled && !rd_tx) |=> tx_disabled)
    else $error("transmitter re-enabled without status read");

  chk_read_reenable: assert property (@(posedge aclk) disable iff (!aresetn) // [RL19]
    (rd_tx && !underrun) |=> !tx_disabled
      && ((q.tx_stat & ~$past(tx_ev)) == 8'h00))
    else $error("transmit status read did not clear");

  chk_alarm_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RL9]
    rd_al |=> ((q.al_stat & ~$past(al_ev)) == 8'h00))
    else $error("alarm status read did not clear");

  chk_read_order: assert property (@(posedge aclk) disable iff (!aresetn) // [RL9]
    rd_al |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(q.al_stat)))
    else $error("alarm read returned wrong snapshot");

  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn) // [RL20]
    event_irq == (|(q.tx_stat & ~q.tx_mask) || |(q.al_stat & ~q.al_mask)))
    else $error("interrupt output disagrees with flags");

  chk_masked_hidden: assert property (@(posedge aclk) disable iff (!aresetn) // [RL10]
    (q.gcfg[ftx_pkg::GCB_VISIBLE] && (q.al_mask == 8'hFF) && $fell(remote_alarm_status_bit)
      && $past(aresetn) && !event_irq && ((tx_ev & ~q.tx_mask) == 8'h00))
      |=> q.al_stat[ftx_pkg::ALB_YEL_CLR] && !event_irq)
    else $error("masked event raised interrupt");

  chk_sue_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RL5]
    (!ss7_mode && !rd_tx && !q.tx_stat[ftx_pkg::TXB_SUE]) |=> !q.tx_stat[ftx_pkg::TXB_SUE])
    else $error("error flag set outside signaling mode");

  chk_yellow_rise: assert property (@(posedge aclk) disable iff (!aresetn) // [RL18]
    ($rose(remote_alarm_status_bit) && !q.al_mask[ftx_pkg::ALB_YEL])
      |=> q.al_stat[ftx_pkg::ALB_YEL])
    else $error("remote alarm rise not flagged");

  chk_frame_regain: assert property (@(posedge aclk) disable iff (!aresetn) // [RL11]
    ($fell(frame_sync_lost) && $past(aresetn) && !q.al_mask[ftx_pkg::ALB_FRAME_REGAIN])
      |=> q.al_stat[ftx_pkg::ALB_FRAME_REGAIN])
    else $error("frame regain not flagged");

  // Edge checks skip the first cycle after reset, where the held history is cleared
  chk_mf_begin: assert property (@(posedge aclk) disable iff (!aresetn) // [RL4]
    (tx_multiframe_start && !q.tx_mask[ftx_pkg::TXB_MF_BEGIN])
      |=> q.tx_stat[ftx_pkg::TXB_MF_BEGIN])
    else $error("multiframe begin not flagged");

  chk_line_short: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
    ($changed(tx_line_short_bit) && $past(aresetn) && !q.tx_mask[ftx_pkg::TXB_LINE_CHG])
      |=> q.tx_stat[ftx_pkg::TXB_LINE_CHG])
    else $error("line short change not flagged");

  chk_pool_ready: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
    ($rose(hdlc_tx_queue_room_32) && $past(aresetn) && !tx_disabled
      && !q.tx_mask[ftx_pkg::TXB_POOL_RDY]) |=> q.tx_stat[ftx_pkg::TXB_POOL_RDY])
    else $error("pool ready not flagged");

  chk_sim_lost: assert property (@(posedge aclk) disable iff (!aresetn) // [RL12]
    (alarm_sim_active && !q.al_mask[ftx_pkg::ALB_FRAME_LOST])
      |=> q.al_stat[ftx_pkg::ALB_FRAME_LOST])
    else $error("frame loss not flagged during simulation");

  chk_mf_lost: assert property (@(posedge aclk) disable iff (!aresetn) // [RL14]
    ($rose(multiframe_sync_lost) && $past(aresetn) && mf_format_f12_f72
      && !q.al_mask[ftx_pkg::ALB_MF_LOST]) |=> q.al_stat[ftx_pkg::ALB_MF_LOST])
    else $error("multiframe loss not flagged");

  chk_blue_fall: assert property (@(posedge aclk) disable iff (!aresetn) // [RL15]
    ($fell(blue_alarm) && $past(aresetn) && q.gcfg[ftx_pkg::GCB_COS]
      && !q.al_mask[ftx_pkg::ALB_BLUE]) |=> q.al_stat[ftx_pkg::ALB_BLUE])
    else $error("blue alarm change not flagged");

  chk_red_rise: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
    ($rose(red_alarm) && $past(aresetn) && !q.al_mask[ftx_pkg::ALB_RED])
      |=> q.al_stat[ftx_pkg::ALB_RED])
    else $error("red alarm rise not flagged");

endmodule : ftx_irq_status

// ### ftx_host_model.sv
// Host-side AXI4-Lite master turning one command into one bus transfer.
module ftx_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic [1:0] resp,
  output logic [7:0] s_axi_awaddr = 8'h00,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  output logic [7:0] s_axi_araddr = 8'h00,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  logic busy = 1'b0;
  assign s_axi_wstrb = 4'hF;
  // Each channel holds its payload until its own ready edge
  always @(posedge aclk) begin
    done <= 1'b0;
    if (!aresetn) begin
      busy <= 1'b0;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
    end else if (req && !busy) begin
      busy <= 1'b1;
      s_axi_awaddr <= addr;
      s_axi_araddr <= addr;
      s_axi_wdata <= wdata;
      s_axi_awvalid <= wr;
      s_axi_wvalid <= wr;
      s_axi_bready <= wr;
      s_axi_arvalid <= !wr;
      s_axi_rready <= !wr;
    end else begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        resp <= s_axi_bresp;
        done <= 1'b1;
        busy <= 1'b0;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rdata <= s_axi_rdata;
        resp <= s_axi_rresp;
        done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule : ftx_host_model

// ### tb_top.sv
// Self-checking bench for the transmit and framer alarm event status block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, h_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, h_wd, h_rd, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, h_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, h_done, ab;
  logic h_req = 1'b0, h_wr = 1'b0, q_empty = 1'b0, f_act = 1'b0, m_end = 1'b0;
  logic sue_bad = 1'b0, sue_ok = 1'b0, sim = 1'b0, cos = 1'b0, dis, abort, irq;
  logic [11:0] v = 12'h000, pv, cv = 12'h000;
  logic [7:0] et, ea;
  logic [31:0] seed = 32'hB0D8;
  int errors = 0;
  int check_count = 0;

  always #5 aclk = ~aclk;

  ftx_irq_status ftx_irq_status_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hdlc_tx_queue_empty(q_empty),
    .tx_frame_active(f_act), .tx_message_end_cmd(m_end), .tx_multiframe_start(v[0]),
    .ss7_mode(v[1]), .sue_count_exceeded(v[2]), .sue_bad_frame(sue_bad),
    .sue_valid_frame(sue_ok), .tx_line_overload_bit(v[3]), .tx_line_short_bit(v[4]),
    .hdlc_tx_queue_room_32(v[5]), .frame_sync_lost(v[6]), .multiframe_sync_lost(v[7]),
    .mf_format_f12_f72(v[8]), .blue_alarm(v[9]), .red_alarm(v[10]),
    .remote_alarm_status_bit(v[11]), .alarm_sim_active(sim), .tx_abort_req(abort),
    .tx_disabled(dis), .event_irq(irq));

  ftx_host_model ftx_host_model_inst (.aclk, .aresetn, .req(h_req), .wr(h_wr), .addr(h_addr),
    .wdata(h_wd), .done(h_done), .rdata(h_rd), .resp(h_resp), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  function automatic logic [31:0] lfsr(logic [31:0] x);
    for (int k = 0; k < 12; k++) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction : lfsr

  // Expected flags from one step of the level inputs
  function automatic logic [7:0] exp_tx(logic [11:0] p, logic [11:0] c);
    return {4'h0, c[0], c[1] & c[2] & !(p[1] & p[2]), (c[3] & !p[3]) | (c[4] ^ p[4]), c[5] & !p[5]};
  endfunction : exp_tx

  function automatic logic [7:0] exp_al(logic [11:0] p, logic [11:0] c, logic s);
    return {p[6] & !c[6], !p[6] & c[6], c[8] & p[7] & !c[7], c[8] & !p[7] & c[7],
      s ? p[9] ^ c[9] : c[9] & !p[9], s ? p[10] ^ c[10] : c[10] & !p[10], p[11] & !c[11],
      c[11] & !p[11]};
  endfunction : exp_al

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    h_req <= 1'b1;
    h_wr <= w;
    h_addr <= a;
    h_wd <= d;
    @(posedge aclk);
    h_req <= 1'b0;
    while (h_done !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 50) errors++;
    rd = h_rd;
  endtask : bus

  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : wait_n

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, 8'(a * 4), 32'h0);
      chk("reset_value", rd, 32'h0);
    end
    bus(1'b0, 8'h18, 32'h0);
    chk("unmapped_resp", {30'h0, h_resp}, {30'h0, ftx_pkg::RESP_SLVERR});
    $display("reset and map test done");
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        bus(1'b1, ftx_pkg::OFS_GLOBAL_CONFIG, 32'h2);
        cos = 1'b1;
      end
      seed = lfsr(seed);
      pv = cv;
      cv = seed[11:0];
      @(posedge aclk);
      v <= cv;
      @(posedge aclk);
      v[0] <= 1'b0;
      et = exp_tx(pv, cv);
      ea = exp_al(pv, cv, cos);
      cv[0] = 1'b0;
      wait_n(1);
      chk("irq", irq, |{et, ea});
      bus(1'b0, ftx_pkg::OFS_GLOBAL_SUMMARY, 32'h0);
      chk("summary", rd, {30'h0, |ea, |et});
      bus(1'b0, ftx_pkg::OFS_TX_STATUS, 32'h0);
      chk("tx_status", rd, et);
      bus(1'b0, ftx_pkg::OFS_ALARM_STATUS, 32'h0);
      chk("alarm_status", rd, ea);
    end
    @(posedge aclk);
    v <= 12'h000;
    cv = 12'h000;
    bus(1'b1, ftx_pkg::OFS_GLOBAL_CONFIG, 32'h0);
    bus(1'b0, ftx_pkg::OFS_TX_STATUS, 32'h0);
    bus(1'b0, ftx_pkg::OFS_ALARM_STATUS, 32'h0);
    $display("random event test done");
    f_act <= 1'b1;
    q_empty <= 1'b1;
    m_end <= 1'b1;
    wait_n(3);
    chk("no_lockout", dis, 1'b0);
    @(posedge aclk);
    m_end <= 1'b0;
    ab = 1'b0;
    for (int k = 0; k < 3; k++) begin
      wait_n(1);
      ab |= abort;
    end
    @(posedge aclk);
    f_act <= 1'b0;
    chk("abort", ab, 1'b1);
    chk("lockout", dis, 1'b1);
    bus(1'b0, ftx_pkg::OFS_TX_STATUS, 32'h0);
    chk("underrun_flag", rd, 32'h10);
    wait_n(2);
    chk("unlocked", dis, 1'b0);
    $display("underrun test done");
    // Underrun stays unmasked, otherwise a lockout goes unnoticed
    bus(1'b1, ftx_pkg::OFS_TX_MASK, 32'h0F);
    chk("write_resp", {30'h0, h_resp}, {30'h0, ftx_pkg::RESP_OKAY});
    bus(1'b1, ftx_pkg::OFS_ALARM_MASK, 32'hFF);
    bus(1'b0, ftx_pkg::OFS_ALARM_MASK, 32'h0);
    chk("mask_rb", rd, 32'hFF);
    v[11] <= 1'b1;
    wait_n(3);
    chk("masked_irq", irq, 1'b0);
    bus(1'b0, ftx_pkg::OFS_ALARM_STATUS, 32'h0);
    chk("masked_hidden", rd, 32'h0);
    bus(1'b1, ftx_pkg::OFS_GLOBAL_CONFIG, 32'h1);
    v[11] <= 1'b0;
    wait_n(3);
    chk("visible_irq", irq, 1'b0);
    bus(1'b0, ftx_pkg::OFS_GLOBAL_SUMMARY, 32'h0);
    chk("visible_sum", rd, 32'h0);
    bus(1'b0, ftx_pkg::OFS_ALARM_STATUS, 32'h0);
    chk("visible_rec", rd, 32'h02);
    bus(1'b1, ftx_pkg::OFS_ALARM_MASK, 32'h0);
    bus(1'b1, ftx_pkg::OFS_TX_MASK, 32'h0);
    bus(1'b1, ftx_pkg::OFS_GLOBAL_CONFIG, 32'h0);
    $display("mask test done");
    v[2:1] <= 2'b11;
    sue_bad <= 1'b1;
    @(posedge aclk);
    sue_bad <= 1'b0;
    bus(1'b0, ftx_pkg::OFS_TX_STATUS, 32'h0);
    chk("sue_first", rd, 32'h04);
    wait_n(1005);
    bus(1'b0, ftx_pkg::OFS_TX_STATUS, 32'h0);
    chk("sue_repeat", rd, 32'h04);
    sue_ok <= 1'b1;
    @(posedge aclk);
    sue_ok <= 1'b0;
    bus(1'b0, ftx_pkg::OFS_TX_STATUS, 32'h0);
    wait_n(1005);
    bus(1'b0, ftx_pkg::OFS_TX_STATUS, 32'h0);
    chk("sue_stopped", rd, 32'h0);
    v[2:1] <= 2'b00;
    $display("signaling error test done");
    sim <= 1'b1;
    wait_n(4);
    bus(1'b0, ftx_pkg::OFS_ALARM_STATUS, 32'h0);
    chk("sim_flags", rd, 32'h7D);
    sim <= 1'b0;
    wait_n(3);
    bus(1'b0, ftx_pkg::OFS_ALARM_STATUS, 32'h0);
    chk("sim_end", rd, 32'hFF);
    bus(1'b0, ftx_pkg::OFS_ALARM_STATUS, 32'h0);
    chk("read_clear", rd, 32'h0);
    $display("alarm simulation test done");
    report_and_stop();
  end
endmodule : tb_top
